// [logic/svrpf_top.sv]
// supervisor: power-on reset, reset inputs, power-fail warning, 32 kHz out, flags
// How it works
// - 32 kHz output runs while supply above switchover and halt bit clear.
// - 32 kHz output starts right after power-up, well inside four seconds.
// - reset output low below trip level, then low for recovery time.
// - each qualified reset input gives the same reset as a power cycle.
// - fast reset input qualifies after 200 ns low; shorter noise ignored.
// - slow reset input qualifies after 100 ms low; shorter noise ignored.
// - after a qualified input releases, reset output stays low recovery time.
// - warning output low while sense input is below threshold.
// - below minimum trip level, warning held low for whole back-up.
// - on power return warning forced high for recovery time, then follows sense.
// - century bit inverts at rollover only when century enable set.
// - with test, alarm and watchdog clear, open-drain pin shows output level bit.
// - battery checked at power-up and daily; low result sets weak flag.
// - weak flag stays until a later check passes.
// - battery checks run only while main supply is up.
// - writes refused during recovery time after supply reaches trip level.
// - recovery time chosen from recovery-length bit and halt bit.
// - initial power-up clears control bits, sets output level and update halt.
// - later power-up keeps some bits, sets update halt, clears the rest.
// - watchdog expiry with steering bit set pulses reset low recovery time.
//
// Implementation choices: the placing of the registers and the strobed register port.
module svrpf_top #(
  parameter int unsigned SLOW_CYC      = svrpf_pkg::SLOW_CYC,
  parameter int unsigned REC_STD_CYC   = svrpf_pkg::REC_STD_CYC,
  parameter int unsigned REC_HALT_CYC  = svrpf_pkg::REC_HALT_CYC,
  parameter int unsigned REC_SHORT_CYC = svrpf_pkg::REC_SHORT_CYC,
  parameter int unsigned SEC_CYC       = svrpf_pkg::SEC_CYC,
  parameter int unsigned DAY_SEC       = svrpf_pkg::T_DAY_S
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       vcc_above_so,
  input  wire logic       vcc_above_min,
  input  wire logic       vcc_above_trip,
  input  wire logic       fail_sense_in,
  input  wire logic       batt_below_meas,
  input  wire logic       ext_reset_in_fast_n,
  input  wire logic       ext_reset_in_slow_n,
  input  wire logic       century_rollover,
  input  wire logic       watchdog_expire,
  output logic            clk32_out,
  output logic            reset_out_n,
  output logic            fail_warn_out_n,
  output logic            irq_test_out_pin_o,
  output logic            irq_test_out_pin_oe,
  output logic            write_protect,
  output logic            batt_check_pulse
);

  svrpf_pkg::svrpf_ctrl_t ctrl_r;
  svrpf_pkg::svrpf_pwr_t  pwr_r;
  svrpf_pkg::svrpf_pwr_t  pwr_nxt;

  logic [31:0] pwr_cnt_r;
  logic [31:0] rst_cnt_r;
  logic [3:0]  fast_cnt_r;
  logic [31:0] slow_cnt_r;
  logic [15:0] half_cnt_r;
  logic [31:0] sec_cnt_r;
  logic [31:0] day_cnt_r;
  logic        battery_weak_flag_r;
  logic        from_backup_r;

  logic        fast_qual;
  logic        slow_qual;
  logic        wd_fire;
  logic        rst_src;
  logic        wr_ok;
  logic        pwr_up_done;
  logic        day_done;
  logic        bat_chk;
  logic [31:0] rec_len;

  // recovery length; halt only matters with the long setting
  function automatic logic [31:0] rec_sel(input logic tr, input logic st);
    logic [31:0] r;
    r = REC_STD_CYC;
    if (tr) begin
      r = REC_SHORT_CYC;
    end else if (st) begin
      r = REC_HALT_CYC;
    end
    return r;
  endfunction

  assign rec_len = rec_sel(ctrl_r.deselect_len_sel, ctrl_r.osc_halt_bit);

  // power state
  always_comb begin
    pwr_nxt = pwr_r;
    if (!vcc_above_min) begin
      pwr_nxt = svrpf_pkg::PWR_BACKUP;
    end else begin
      case (pwr_r)
        svrpf_pkg::PWR_BACKUP: begin
          pwr_nxt = vcc_above_trip ? svrpf_pkg::PWR_RECOVER : svrpf_pkg::PWR_LOW;
        end
        svrpf_pkg::PWR_LOW: begin
          if (vcc_above_trip) begin
            pwr_nxt = svrpf_pkg::PWR_RECOVER;
          end
        end
        svrpf_pkg::PWR_RECOVER: begin
          if (!vcc_above_trip) begin
            pwr_nxt = svrpf_pkg::PWR_LOW;
          end else if (pwr_cnt_r <= 32'h0000_0001) begin
            pwr_nxt = svrpf_pkg::PWR_RUN;
          end
        end
        default: begin
          if (!vcc_above_trip) begin
            pwr_nxt = svrpf_pkg::PWR_LOW;
          end
        end
      endcase
    end
  end

  // initial power application counts as a return from back-up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwr_r <= svrpf_pkg::PWR_BACKUP;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      from_backup_r <= 1'b1;
    end else if (pwr_r == svrpf_pkg::PWR_BACKUP) begin
      from_backup_r <= 1'b1;
    end else if (pwr_nxt == svrpf_pkg::PWR_RUN) begin
      from_backup_r <= 1'b0;
    end
  end

  // write-protect window, reloaded while supply is under the trip level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwr_cnt_r <= 32'h0000_0000;
    end else if (pwr_r != svrpf_pkg::PWR_RECOVER) begin
      pwr_cnt_r <= rec_len;
    end else if (pwr_cnt_r != 32'h0000_0000) begin
      pwr_cnt_r <= pwr_cnt_r - 32'h0000_0001;
    end
  end

  assign pwr_up_done = (pwr_r == svrpf_pkg::PWR_RECOVER) && (pwr_nxt == svrpf_pkg::PWR_RUN);
  assign wr_ok       = (pwr_r == svrpf_pkg::PWR_RUN);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      write_protect <= 1'b1;
    end else begin
      write_protect <= (pwr_nxt != svrpf_pkg::PWR_RUN);
    end
  end

  // reset input qualification, both counted on the system clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fast_cnt_r <= 4'h0;
    end else if (ext_reset_in_fast_n) begin
      fast_cnt_r <= 4'h0;
    end else if (fast_cnt_r < 4'(svrpf_pkg::FAST_CYC)) begin
      fast_cnt_r <= fast_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slow_cnt_r <= 32'h0000_0000;
    end else if (ext_reset_in_slow_n) begin
      slow_cnt_r <= 32'h0000_0000;
    end else if (slow_cnt_r < SLOW_CYC) begin
      slow_cnt_r <= slow_cnt_r + 32'h0000_0001;
    end
  end

  // qualifies on the last required low sample, and only while still low
  assign fast_qual = !ext_reset_in_fast_n && (fast_cnt_r >= 4'(svrpf_pkg::FAST_CYC - 1));
  assign slow_qual = !ext_reset_in_slow_n && (slow_cnt_r >= SLOW_CYC - 1);
  assign wd_fire   = watchdog_expire && ctrl_r.watchdog_reg[svrpf_pkg::B_WDS];
  assign rst_src   = (pwr_r == svrpf_pkg::PWR_BACKUP) || (pwr_r == svrpf_pkg::PWR_LOW)
                   || fast_qual || slow_qual;

  // one stretch counter serves every reset source
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_cnt_r <= 32'h0000_0000;
    end else if (rst_src || wd_fire) begin
      rst_cnt_r <= rec_len;
    end else if (rst_cnt_r != 32'h0000_0000) begin
      rst_cnt_r <= rst_cnt_r - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reset_out_n <= 1'b0;
    end else begin
      reset_out_n <= !(rst_src || wd_fire || (rst_cnt_r > 32'h0000_0001));
    end
  end

  // warning output
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fail_warn_out_n <= 1'b0;
    end else if (pwr_r == svrpf_pkg::PWR_BACKUP) begin
      fail_warn_out_n <= 1'b0;
    end else if (from_backup_r) begin
      // comparator stays off until the recovery window has run out
      fail_warn_out_n <= (pwr_r == svrpf_pkg::PWR_RECOVER);
    end else begin
      fail_warn_out_n <= !fail_sense_in;
    end
  end

  // 32 kHz output; free divider so the first edge comes at once
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      half_cnt_r <= 16'h0000;
    end else if (half_cnt_r >= 16'(svrpf_pkg::F32_HALF_CYC - 1)) begin
      half_cnt_r <= 16'h0000;
    end else begin
      half_cnt_r <= half_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clk32_out <= 1'b0;
    end else if (!vcc_above_so || ctrl_r.osc_halt_bit) begin
      clk32_out <= 1'b0;
    end else if (half_cnt_r == 16'h0000) begin
      clk32_out <= !clk32_out;
    end
  end

  // daily battery check schedule, held at zero outside normal supply
  assign day_done = (sec_cnt_r == SEC_CYC - 1) && (day_cnt_r == DAY_SEC - 1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sec_cnt_r <= 32'h0000_0000;
      day_cnt_r <= 32'h0000_0000;
    end else if (pwr_r != svrpf_pkg::PWR_RUN) begin
      sec_cnt_r <= 32'h0000_0000;
      day_cnt_r <= 32'h0000_0000;
    end else if (sec_cnt_r == SEC_CYC - 1) begin
      sec_cnt_r <= 32'h0000_0000;
      day_cnt_r <= day_done ? 32'h0000_0000 : day_cnt_r + 32'h0000_0001;
    end else begin
      sec_cnt_r <= sec_cnt_r + 32'h0000_0001;
    end
  end

  assign bat_chk = pwr_up_done || ((pwr_r == svrpf_pkg::PWR_RUN) && day_done);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      battery_weak_flag_r <= 1'b0;
      batt_check_pulse    <= 1'b0;
    end else begin
      batt_check_pulse <= bat_chk;
      if (bat_chk) begin
        battery_weak_flag_r <= batt_below_meas;
      end
    end
  end

  // control registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= svrpf_pkg::CTRL_RST;
    end else if (pwr_r == svrpf_pkg::PWR_BACKUP && pwr_nxt != svrpf_pkg::PWR_BACKUP) begin
      ctrl_r.update_halt_bit <= 1'b1;
      ctrl_r.freq_test_bit   <= 1'b0;
      ctrl_r.alarm_irq_en    <= 1'b0;
      ctrl_r.alarm_backup_en <= 1'b0;
      ctrl_r.square_wave_en  <= 1'b0;
      ctrl_r.watchdog_reg    <= 8'h00;
    end else if (wd_fire) begin
      // steered expiry wipes the watchdog and output enables
      ctrl_r.freq_test_bit   <= 1'b0;
      ctrl_r.alarm_irq_en    <= 1'b0;
      ctrl_r.alarm_backup_en <= 1'b0;
      ctrl_r.square_wave_en  <= 1'b0;
      ctrl_r.watchdog_reg    <= 8'h00;
    end else begin
      if (reg_wr && wr_ok) begin
        if (reg_addr == svrpf_pkg::A_STOP) begin
          ctrl_r.osc_halt_bit <= reg_wdata[svrpf_pkg::B_ST];
        end else if (reg_addr == svrpf_pkg::A_RECOVERY_TIME) begin
          ctrl_r.deselect_len_sel <= reg_wdata[svrpf_pkg::B_TR];
        end else if (reg_addr == svrpf_pkg::A_CTRL) begin
          ctrl_r.out_level_bit <= reg_wdata[svrpf_pkg::B_OUT];
          ctrl_r.freq_test_bit <= reg_wdata[svrpf_pkg::B_FT];
        end else if (reg_addr == svrpf_pkg::A_WDOG) begin
          ctrl_r.watchdog_reg <= reg_wdata;
        end else if (reg_addr == svrpf_pkg::A_ALARM) begin
          ctrl_r.alarm_irq_en    <= reg_wdata[svrpf_pkg::B_AFE];
          ctrl_r.square_wave_en  <= reg_wdata[svrpf_pkg::B_SQUARE_WAVE_EN];
          ctrl_r.alarm_backup_en <= reg_wdata[svrpf_pkg::B_ABE];
        end else if (reg_addr == svrpf_pkg::A_HALT) begin
          ctrl_r.update_halt_bit <= reg_wdata[svrpf_pkg::B_HT];
        end
      end
    end
  end

  // century pair kept apart so a rollover on a write cycle still lands
  logic [1:0] century_r;
  logic [1:0] century_nxt;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      century_r <= 2'b00;
    end else begin
      century_r <= century_nxt;
    end
  end

  always_comb begin
    century_nxt = century_r;
    if (reg_wr && wr_ok && reg_addr == svrpf_pkg::A_CENTURY) begin
      century_nxt = {reg_wdata[svrpf_pkg::B_CEB], reg_wdata[svrpf_pkg::B_CB]};
    end
    if (century_rollover && century_nxt[1]) begin
      century_nxt[0] = !century_nxt[0];
    end
  end

  // open-drain pin: only the plain output function lives here
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_test_out_pin_oe <= 1'b0;
    end else begin
      irq_test_out_pin_oe <= !ctrl_r.freq_test_bit && !ctrl_r.alarm_irq_en
                          && (ctrl_r.watchdog_reg == 8'h00) && !ctrl_r.out_level_bit;
    end
  end

  assign irq_test_out_pin_o = 1'b0;

  // read port, data in the cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == svrpf_pkg::A_STOP) begin
        reg_rdata <= {ctrl_r.osc_halt_bit, 7'h00};
      end else if (reg_addr == svrpf_pkg::A_CENTURY) begin
        reg_rdata <= {century_r, 6'h00};
      end else if (reg_addr == svrpf_pkg::A_RECOVERY_TIME) begin
        reg_rdata <= {ctrl_r.deselect_len_sel, 7'h00};
      end else if (reg_addr == svrpf_pkg::A_CTRL) begin
        reg_rdata <= {ctrl_r.out_level_bit, ctrl_r.freq_test_bit, 6'h00};
      end else if (reg_addr == svrpf_pkg::A_WDOG) begin
        reg_rdata <= ctrl_r.watchdog_reg;
      end else if (reg_addr == svrpf_pkg::A_ALARM) begin
        reg_rdata <= {ctrl_r.alarm_irq_en, ctrl_r.square_wave_en,
                      ctrl_r.alarm_backup_en, 5'h00};
      end else if (reg_addr == svrpf_pkg::A_HALT) begin
        reg_rdata <= {1'b0, ctrl_r.update_halt_bit, 6'h00};
      end else if (reg_addr == svrpf_pkg::A_FLAGS) begin
        reg_rdata <= {3'h0, battery_weak_flag_r, 4'h0};
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// [pkg/svrpf_pkg.sv]
// shared constants and types of the supervisor, reset and power-fail block
package svrpf_pkg;

  // clock
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned CLK_NS        = 20;
  localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;

  // reset input widths
  localparam int unsigned T_FAST_NS     = 200;
  localparam int unsigned FAST_CYC      = (T_FAST_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned T_SLOW_MS     = 100;
  localparam int unsigned SLOW_CYC      = T_SLOW_MS * 1000 * CLK_PER_US;

  // recovery times, one point inside each window
  localparam int unsigned T_REC_STD_US  = 97_000;
  localparam int unsigned T_REC_HALT_US = 100_000;
  localparam int unsigned T_REC_SHORT_US = 1_000;
  localparam int unsigned REC_STD_CYC   = T_REC_STD_US * CLK_PER_US;
  localparam int unsigned REC_HALT_CYC  = T_REC_HALT_US * CLK_PER_US;
  localparam int unsigned REC_SHORT_CYC = T_REC_SHORT_US * CLK_PER_US;

  // 32 kHz output and battery check schedule
  localparam int unsigned F32_HZ        = 32_768;
  localparam int unsigned F32_HALF_CYC  = CLK_HZ / (2 * F32_HZ);
  localparam int unsigned SEC_CYC       = CLK_HZ;
  localparam int unsigned T_DAY_S       = 86_400;

  // register offsets
  localparam logic [4:0] A_STOP    = 5'h01;
  localparam logic [4:0] A_CENTURY = 5'h03;
  localparam logic [4:0] A_RECOVERY_TIME    = 5'h04;
  localparam logic [4:0] A_CTRL    = 5'h08;
  localparam logic [4:0] A_WDOG    = 5'h09;
  localparam logic [4:0] A_ALARM   = 5'h0a;
  localparam logic [4:0] A_HALT    = 5'h0c;
  localparam logic [4:0] A_FLAGS   = 5'h0f;

  // field positions
  localparam int unsigned B_ST   = 7;
  localparam int unsigned B_CEB  = 7;
  localparam int unsigned B_CB   = 6;
  localparam int unsigned B_TR   = 7;
  localparam int unsigned B_OUT  = 7;
  localparam int unsigned B_FT   = 6;
  localparam int unsigned B_WDS  = 7;
  localparam int unsigned B_AFE  = 7;
  localparam int unsigned B_SQUARE_WAVE_EN = 6;
  localparam int unsigned B_ABE  = 5;
  localparam int unsigned B_HT   = 6;
  localparam int unsigned B_BL   = 4;

  typedef struct packed {
    logic       osc_halt_bit;
    logic       century_count_en;
    logic       century_toggle_bit;
    logic       deselect_len_sel;
    logic       out_level_bit;
    logic       freq_test_bit;
    logic       alarm_irq_en;
    logic       alarm_backup_en;
    logic       square_wave_en;
    logic       update_halt_bit;
    logic [7:0] watchdog_reg;
  } svrpf_ctrl_t;

  // initial power application values
  localparam svrpf_ctrl_t CTRL_RST = '{
    osc_halt_bit: 1'b0, century_count_en: 1'b0, century_toggle_bit: 1'b0,
    deselect_len_sel: 1'b0, out_level_bit: 1'b1, freq_test_bit: 1'b0,
    alarm_irq_en: 1'b0, alarm_backup_en: 1'b0, square_wave_en: 1'b0,
    update_halt_bit: 1'b1, watchdog_reg: 8'h00};

  typedef enum logic [1:0] {
    PWR_BACKUP, PWR_LOW, PWR_RECOVER, PWR_RUN
  } svrpf_pwr_t;

endpackage

// [test/svrpf_checker.sv]
// port assertions of the supervisor block
module svrpf_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic vcc_above_so,
  input wire logic vcc_above_min,
  input wire logic vcc_above_trip,
  input wire logic fail_sense_in,
  input wire logic ext_reset_in_fast_n,
  input wire logic clk32_out,
  input wire logic reset_out_n,
  input wire logic fail_warn_out_n,
  input wire logic irq_test_out_pin_o,
  input wire logic write_protect,
  input wire logic batt_check_pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // saturates so a long hold never wraps back to the trigger value
  logic [3:0] fast_cnt_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) fast_cnt_r <= 4'h0;
    else if (ext_reset_in_fast_n) fast_cnt_r <= 4'h0;
    else if (fast_cnt_r != 4'hf) fast_cnt_r <= fast_cnt_r + 4'h1;
  end
  fast_qualify_a: assert property (fast_cnt_r == 4'ha |-> ##[0:3] !reset_out_n)
    else $error("fast reset input not qualified");
  release_hold_a: assert property ($rose(ext_reset_in_fast_n) && !reset_out_n
    |=> !reset_out_n [*8]) else $error("reset output released early");
  trip_reset_a: assert property (!vcc_above_trip |-> ##[0:2] !reset_out_n)
    else $error("reset output high below trip");
  trip_protect_a: assert property (!vcc_above_trip |-> ##[0:2] write_protect)
    else $error("writes open below trip");
  backup_warn_a: assert property (!vcc_above_min |-> ##[0:2] !fail_warn_out_n)
    else $error("warning high in back-up");
  warn_follow_a: assert property (!write_protect && !$past(write_protect)
    && $past(vcc_above_min) |-> fail_warn_out_n == !$past(fail_sense_in))
    else $error("warning does not follow sense");
  clk32_stop_a: assert property (!vcc_above_so [*3] |-> !clk32_out)
    else $error("32k output runs in back-up");
  clk32_half_a: assert property ($rose(clk32_out)
    |=> (clk32_out || !vcc_above_so) [*8]) else $error("32k high phase too short");
  batt_backup_a: assert property (batt_check_pulse |-> $past(vcc_above_min, 2))
    else $error("battery check in back-up");
  pin_open_a: assert property (!irq_test_out_pin_o)
    else $error("open-drain pin driven high");
endmodule

// [test/svrpf_host_model.sv]
// host model: drives both reset inputs, counts resets, sees the open-drain pin
module svrpf_host_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        sel_slow,
  input  wire logic [15:0] low_len,
  input  wire logic        reset_out_n,
  input  wire logic        pin_oe,
  output logic             fast_n,
  output logic             slow_n,
  output logic             busy,
  output logic             pin_level,
  output logic [7:0]       resets_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_r;
  logic        seen_q;
  // pull-up wins whenever nobody pulls low
  assign pin_level = !pin_oe;
  initial begin
    {fast_n, slow_n, seen_q, busy} = 4'he;
    cnt_r = 16'h0000;
    resets_seen = 8'h00;
  end
  always @(posedge clk) begin
    seen_q <= reset_out_n;
    if (seen_q && !reset_out_n) resets_seen <= resets_seen + 8'h01;
  end
  // input held low for exactly low_len edges, then back to the pull-up
  always @(posedge clk) begin
    if (go && !busy) begin
      busy   <= 1'b1;
      cnt_r  <= low_len;
      fast_n <= sel_slow;
      slow_n <= !sel_slow;
    end else if (busy && cnt_r > 16'h0001) begin
      cnt_r <= cnt_r - 16'h0001;
    end else if (busy) begin
      busy <= 1'b0;
      {fast_n, slow_n} <= 2'b11;
    end
  end
endmodule

// [test/tb_supervisor_reset_power_fail.sv]
// self-checking bench of the supervisor block
module tb_supervisor_reset_power_fail;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOW = 40;
  localparam int REC_STD = 50;
  localparam int REC_HALT = 60;
  localparam int REC_SHORT = 20;
  logic        clk = 1'b0;
  logic        nrst, reg_wr, reg_rd, vcc_above_so, vcc_above_min, vcc_above_trip;
  logic        fail_sense_in, batt_below_meas, century_rollover, watchdog_expire;
  logic        clk32_out, reset_out_n, fail_warn_out_n, irq_test_out_pin_o, write_protect;
  logic        irq_test_out_pin_oe, batt_check_pulse, go, sel_slow, busy, pin_level;
  logic        ext_reset_in_fast_n, ext_reset_in_slow_n;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, resets_seen;
  logic [15:0] low_len;
  int          errors = 0, tests_run = 0;
  int          n, t;
  svrpf_top #(.SLOW_CYC(SLOW), .REC_STD_CYC(REC_STD), .REC_HALT_CYC(REC_HALT),
    .REC_SHORT_CYC(REC_SHORT), .SEC_CYC(10), .DAY_SEC(3)) i_dut (
    .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .vcc_above_so,
    .vcc_above_min, .vcc_above_trip, .fail_sense_in, .batt_below_meas,
    .ext_reset_in_fast_n, .ext_reset_in_slow_n, .century_rollover, .watchdog_expire,
    .clk32_out, .reset_out_n, .fail_warn_out_n, .irq_test_out_pin_o,
    .irq_test_out_pin_oe, .write_protect, .batt_check_pulse);
  svrpf_host_model i_host (.clk, .go, .sel_slow, .low_len, .reset_out_n,
    .pin_oe(irq_test_out_pin_oe), .fast_n(ext_reset_in_fast_n),
    .slow_n(ext_reset_in_slow_n), .busy, .pin_level, .resets_seen);
  always #10 clk = !clk;
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input string w, input logic [4:0] a, input logic [7:0] m,
                       input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(w, reg_rdata & m, exp);
  endtask
  // bounded wait: 0 reset output, 1 write protect, 2 battery check pulse
  task automatic wait_for(input int sel, input logic lvl, input int lim);
    n = 0;
    while ((sel == 0 ? reset_out_n : sel == 1 ? write_protect : batt_check_pulse) !== lvl
           && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // rec of zero means the pulse is noise and must leave no reset
  task automatic rec_test(input string w, input logic slow, input int len, input int rec);
    logic [7:0] base;
    base = resets_seen;
    @(posedge clk);
    sel_slow <= slow;
    low_len <= 16'(len);
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    while (busy === 1'b1) @(posedge clk);
    cyc(1);
    if (rec == 0) begin
      cyc(5);
      check(w, resets_seen, base);
    end else begin
      check(w, {7'h00, reset_out_n}, 8'h00);
      wait_for(0, 1'b1, rec + 20);
      check(w, {7'h00, n + 4 >= rec && n <= rec + 4}, 8'h01);
    end
  endtask
  task automatic count32(input int k);
    logic q;
    t = 0;
    q = clk32_out;
    repeat (k) begin
      cyc(1);
      if (clk32_out !== q) t++;
      q = clk32_out;
    end
  endtask
  task automatic pulse(input logic wd);
    @(posedge clk);
    {watchdog_expire, century_rollover} <= {wd, !wd};
    @(posedge clk);
    {watchdog_expire, century_rollover} <= 2'b00;
  endtask
  // two pulses, so the second check surely sampled the new battery level
  task automatic batt_step(input logic v);
    batt_below_meas <= v;
    wait_for(2, 1'b1, 60);
    cyc(1);
    wait_for(2, 1'b1, 60);
    rdchk("battery flag", svrpf_pkg::A_FLAGS, 8'h10, {3'h0, v, 4'h0});
  endtask
  task automatic done(input string w);
    $display("test %s finished", w);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #1_500_000;
    errors++;
    summarize();
  end
  initial begin
    {nrst, reg_wr, reg_rd, go, sel_slow, fail_sense_in, batt_below_meas} = 7'h00;
    {century_rollover, watchdog_expire, reg_addr, reg_wdata, low_len} = 31'h0;
    {vcc_above_so, vcc_above_min, vcc_above_trip} = 3'b111;
    cyc(12);
    check("reset held", {5'h00, reset_out_n, fail_warn_out_n, write_protect}, 8'h01);
    nrst <= 1'b1;
    wr(svrpf_pkg::A_CTRL, 8'h00);
    wait_for(1, 1'b0, 200);
    check("protect span", {7'h00, n + 6 >= REC_STD && n <= REC_STD + 4}, 8'h01);
    wait_for(0, 1'b1, 10);
    check("power-on reset", {7'h00, reset_out_n}, 8'h01);
    count32(2000);
    check("32k running", {7'h00, t >= 2}, 8'h01);
    rdchk("tr", svrpf_pkg::A_RECOVERY_TIME, 8'h80, 8'h00);
    rdchk("halt", svrpf_pkg::A_STOP, 8'h80, 8'h00);
    rdchk("out ft", svrpf_pkg::A_CTRL, 8'hc0, 8'h80);
    rdchk("watchdog", svrpf_pkg::A_WDOG, 8'hff, 8'h00);
    rdchk("alarm", svrpf_pkg::A_ALARM, 8'he0, 8'h00);
    rdchk("update halt", svrpf_pkg::A_HALT, 8'h40, 8'h40);
    rdchk("unmapped", 5'h1f, 8'hff, 8'h00);
    done("defaults");
    check("pin high", {7'h00, pin_level}, 8'h01);
    wr(svrpf_pkg::A_CTRL, 8'h00);
    cyc(2);
    check("pin low", {7'h00, pin_level}, 8'h00);
    wr(svrpf_pkg::A_ALARM, 8'h80);
    cyc(2);
    check("pin released", {7'h00, pin_level}, 8'h01);
    wr(svrpf_pkg::A_ALARM, 8'h00);
    wr(svrpf_pkg::A_CENTURY, 8'h80);
    pulse(1'b0);
    rdchk("century on", svrpf_pkg::A_CENTURY, 8'hc0, 8'hc0);
    pulse(1'b0);
    rdchk("century back", svrpf_pkg::A_CENTURY, 8'hc0, 8'h80);
    wr(svrpf_pkg::A_CENTURY, 8'h40);
    pulse(1'b0);
    rdchk("century fixed", svrpf_pkg::A_CENTURY, 8'hc0, 8'h40);
    done("pin and century");
    rec_test("fast noise", 1'b0, 9, 0);
    rec_test("fast reset", 1'b0, 10, REC_STD);
    rec_test("slow noise", 1'b1, SLOW - 1, 0);
    rec_test("slow reset", 1'b1, SLOW, REC_STD);
    wr(svrpf_pkg::A_RECOVERY_TIME, 8'h80);
    rec_test("short recovery", 1'b0, 12, REC_SHORT);
    wr(svrpf_pkg::A_RECOVERY_TIME, 8'h00);
    wr(svrpf_pkg::A_STOP, 8'h80);
    rec_test("halt recovery", 1'b0, 12, REC_HALT);
    count32(2000);
    check("32k halted", {7'h00, t == 0 && clk32_out === 1'b0}, 8'h01);
    wr(svrpf_pkg::A_STOP, 8'h00);
    wr(svrpf_pkg::A_WDOG, 8'h80);
    pulse(1'b1);
    wait_for(0, 1'b0, 5);
    wait_for(0, 1'b1, REC_STD + 20);
    check("watchdog reset", {7'h00, n + 6 >= REC_STD && n <= REC_STD + 4}, 8'h01);
    done("reset sources");
    fail_sense_in <= 1'b1;
    cyc(3);
    check("warn low", {7'h00, fail_warn_out_n}, 8'h00);
    fail_sense_in <= 1'b0;
    cyc(3);
    check("warn high", {7'h00, fail_warn_out_n}, 8'h01);
    wr(svrpf_pkg::A_ALARM, 8'he0);
    wr(svrpf_pkg::A_HALT, 8'h00);
    @(posedge clk);
    {vcc_above_so, vcc_above_min, vcc_above_trip} <= 3'b000;
    cyc(3);
    batt_below_meas <= 1'b1;
    wait_for(2, 1'b1, 100);
    check("no check in back-up", {7'h00, n == 100}, 8'h01);
    check("back-up outputs", {6'h00, fail_warn_out_n, reset_out_n}, 8'h00);
    {vcc_above_so, vcc_above_min, vcc_above_trip} <= 3'b111;
    fail_sense_in <= 1'b1;
    cyc(3);
    check("warn forced", {7'h00, fail_warn_out_n}, 8'h01);
    wr(svrpf_pkg::A_CTRL, 8'h80);
    wait_for(1, 1'b0, 200);
    cyc(3);
    check("warn follows", {7'h00, fail_warn_out_n}, 8'h00);
    fail_sense_in <= 1'b0;
    rdchk("power-up check", svrpf_pkg::A_FLAGS, 8'h10, 8'h10);
    rdchk("out kept", svrpf_pkg::A_CTRL, 8'hc0, 8'h00);
    rdchk("alarm cleared", svrpf_pkg::A_ALARM, 8'he0, 8'h00);
    rdchk("halt set", svrpf_pkg::A_HALT, 8'h40, 8'h40);
    rdchk("wd cleared", svrpf_pkg::A_WDOG, 8'hff, 8'h00);
    done("power fail");
    batt_step(1'b0);
    batt_step(1'b1);
    batt_step(1'b0);
    done("battery");
    summarize();
  end
endmodule
bind svrpf_top svrpf_checker i_chk (.clk(clk), .nrst(nrst), .vcc_above_so(vcc_above_so),
  .vcc_above_min(vcc_above_min), .vcc_above_trip(vcc_above_trip),
  .fail_sense_in(fail_sense_in), .ext_reset_in_fast_n(ext_reset_in_fast_n),
  .clk32_out(clk32_out), .reset_out_n(reset_out_n), .fail_warn_out_n(fail_warn_out_n),
  .irq_test_out_pin_o(irq_test_out_pin_o), .write_protect(write_protect),
  .batt_check_pulse(batt_check_pulse));
